// >>> adcs_pkg.sv
/*
  Package for the converter control sequencer: register offsets, field
  positions, reset values, trigger codes, sequencer states, carrier structs.
  Assumes a 32-bit AHB-Lite register bus and a converter core on hclk.
*/
package adcs_pkg;
  localparam logic [7:0]  OFF_CTRL1   = 8'h00;
  localparam logic [7:0]  OFF_CTRL2   = 8'h04;
  localparam logic [7:0]  OFF_STAT    = 8'h08;
  localparam logic [1:0]  BUF_PAGE    = 2'h1;
  localparam int          B_ON        = 15;
  localparam int          B_HALT      = 13;
  localparam int          B_WIDE      = 10;
  localparam int          B_LAY       = 8;
  localparam int          B_TRIG      = 5;
  localparam int          B_PAR       = 3;
  localparam int          B_AUTO      = 2;
  localparam int          B_ACQUIRE_PHASE_BIT      = 1;
  localparam int          B_DONE      = 0;
  localparam int          B_CC        = 0;
  localparam int          B_ACQT      = 8;
  localparam int          B_DIV       = 16;
  localparam logic [15:0] CTRL1_RESET = 16'h0000;
  localparam logic [4:0]  ACQT_RESET  = 5'h00;
  localparam logic [7:0]  DIV_RESET   = 8'h00;
  localparam logic [2:0]  T_SW        = 3'h0;
  localparam logic [2:0]  T_EXTERNAL_INTERRUPT_PIN_ZERO      = 3'h1;
  localparam logic [2:0]  T_TMR3      = 3'h2;
  localparam logic [2:0]  T_PWM1      = 3'h3;
  localparam logic [2:0]  T_PWM2      = 3'h5;
  localparam logic [2:0]  T_AUTO      = 3'h7;
  localparam int          SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    S_IDLE    = 2'h0,
    S_SAMPLE  = 2'h1,
    S_CONVERT = 2'h3
  } adcs_state_type;

  typedef struct packed {
    logic       start;
    logic       wide;
    logic [1:0] chan;
  } adcs_core_req_type;

  typedef struct packed {
    logic        done;
    logic [11:0] data;
  } adcs_core_rsp_type;

  typedef struct packed {
    logic tmr3;
    logic pwm1;
    logic pwm2;
  } adcs_trig_type;
endpackage

// >>> adcs_sync.sv
/*
  Three-stage synchroniser with edge detect for the external interrupt pin.
  Assumes an asynchronous pin; a level counts once stages two and three agree.
*/
`timescale 1ns/1ns
`default_nettype none
module adcs_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin,
  output var  logic rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
      rise  <= 1'b0;
    end else begin
      s1_q  <= pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= (s2_q == s3_q) ? s3_q : lvl_q;
      rise  <= (s2_q == s3_q) && s3_q && !lvl_q;
    end
  end
endmodule
`default_nettype wire

// >>> adcs_format.sv
/*
  Result word layout for 10-bit and 12-bit samples.
  Assumes raw data right-justified from the converter core.
*/
`timescale 1ns/1ns
`default_nettype none
module adcs_format (
  input  wire logic        wide,
  input  wire logic [1:0]  layout,
  input  wire logic [11:0] raw,
  output var  logic [15:0] word
);
  logic [15:0] w10;
  logic [15:0] w12;

  always_comb begin
    case (layout)
      2'h0: w10 = {6'h00, raw[9:0]};
      2'h1: w10 = {{7{~raw[9]}}, raw[8:0]};
      2'h2: w10 = {raw[9:0], 6'h00};
      default: w10 = {~raw[9], raw[8:0], 6'h00};
    endcase
    case (layout)
      2'h0: w12 = {4'h0, raw};
      2'h1: w12 = {{5{~raw[11]}}, raw[10:0]};
      2'h2: w12 = {raw, 4'h0};
      default: w12 = {~raw[11], raw[10:0], 4'h0};
    endcase
    word = wide ? w12 : w10;
  end
endmodule
`default_nettype wire

// >>> adcs_top.sv
/*
  Converter control sequencer: control registers on AHB-Lite, sample and
  convert sequencer, trigger selection, result buffer.
  Assumes a converter core that answers each start with one done pulse,
  trigger pulses from timers on hclk, and an asynchronous interrupt pin.
*/
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module adcs_top #(
  parameter int BUF_DEPTH = 16
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [7:0]                 haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output var  logic                       hreadyout,
  output var  logic [31:0]                hrdata,
  output var  logic                       hresp,
  input  wire logic                       chip_idle,
  input  wire logic                       ext_pin_zero,
  input  wire adcs_pkg::adcs_trig_type    trig_in,
  input  wire adcs_pkg::adcs_core_rsp_type core_rsp,
  output var  adcs_pkg::adcs_core_req_type core_req,
  output var  logic [3:0]                 sample_hold
);
  import adcs_pkg::*;

  if (BUF_DEPTH != 16) begin : g_chk
    $error("result buffer depth must be 16");
  end

  function automatic logic [1:0] last_chan(input logic w, input logic [1:0] cc);
    last_chan = w ? 2'h0 : (cc[1] ? 2'h3 : (cc[0] ? 2'h1 : 2'h0));
  endfunction

  function automatic logic [3:0] chan_mask(input logic w, input logic [1:0] cc);
    chan_mask = w ? 4'h1 : (cc[1] ? 4'hF : (cc[0] ? 4'h3 : 4'h1));
  endfunction

  adcs_state_type st_q;
  adcs_state_type st_d;
  logic        on_q;
  logic        halt_q;
  logic        wide_q;
  logic [1:0]  lay_q;
  logic [2:0]  trig_q;
  logic        par_q;
  logic        auto_q;
  logic        done_q;
  logic [1:0]  cc_q;
  logic [4:0]  acqt_q;
  logic [7:0]  div_q;
  logic [7:0]  tad_q;
  logic [4:0]  acq_q;
  logic [1:0]  idx_q;
  logic [1:0]  idx_d;
  logic [3:0]  wp_q;
  logic [15:0] buf_q [BUF_DEPTH];
  logic        wr_q;
  logic        rd_q;
  logic [7:0]  addr_q;
  logic        start_d;
  logic        store;
  logic [31:0] rmux;
  logic [15:0] fmt_word;
  logic        external_interrupt_pin_zero_rise;

  wire acc      = hsel && htrans[1] && hready;
  wire wr_c1    = wr_q && (addr_q == OFF_CTRL1);
  wire wr_c2    = wr_q && (addr_q == OFF_CTRL2);
  wire run      = on_q && !(halt_q && chip_idle);
  wire par_eff  = par_q && !wide_q;
  wire [1:0] cc_eff = wide_q ? 2'h0 : cc_q;
  wire last     = (idx_q == last_chan(wide_q, cc_q));
  wire sampling = (st_q == S_SAMPLE);
  wire tad_tick = (tad_q == div_q);
  wire auto_fire = sampling && ((acqt_q == 5'h00) || (tad_tick && (acq_q + 5'h01 >= acqt_q)));
  wire sw_start = wr_c1 && hwdata[B_ACQUIRE_PHASE_BIT] && !auto_q && (st_q == S_IDLE);
  wire sw_end   = wr_c1 && !hwdata[B_ACQUIRE_PHASE_BIT] && sampling;
  wire trig_evt = (trig_q == T_SW)   ? sw_end :
                  (trig_q == T_EXTERNAL_INTERRUPT_PIN_ZERO) ? external_interrupt_pin_zero_rise :
                  (trig_q == T_TMR3) ? trig_in.tmr3 :
                  (trig_q == T_PWM1) ? trig_in.pwm1 :
                  (trig_q == T_PWM2) ? trig_in.pwm2 :
                  (trig_q == T_AUTO) ? auto_fire : 1'b0;
  wire fin      = store && last;
  wire [15:0] ctrl1_rd = {on_q, 1'b0, halt_q, 2'h0, wide_q, lay_q, trig_q,
                          1'b0, par_eff, auto_q, sampling, done_q};

  adcs_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (ext_pin_zero),
    .rise    (external_interrupt_pin_zero_rise)
  );

  adcs_format u_format (
    .wide   (wide_q),
    .layout (lay_q),
    .raw    (core_rsp.data),
    .word   (fmt_word)
  );

  always_comb begin
    st_d    = st_q;
    idx_d   = idx_q;
    start_d = 1'b0;
    store   = 1'b0;
    if (!run) begin
      st_d  = S_IDLE;
      idx_d = 2'h0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (auto_q || sw_start) begin
            st_d = S_SAMPLE;
          end
        end
        S_SAMPLE: begin
          if (trig_evt) begin
            st_d    = S_CONVERT;
            start_d = 1'b1;
          end
        end
        S_CONVERT: begin
          if (core_rsp.done) begin
            store = 1'b1;
            if (!last) begin
              idx_d = idx_q + 2'h1;
              if (par_eff) begin
                start_d = 1'b1;
              end else begin
                st_d = S_SAMPLE;
              end
            end else begin
              idx_d = 2'h0;
              st_d  = auto_q ? S_SAMPLE : S_IDLE;
            end
          end
        end
        default: begin
          st_d = S_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rmux = 32'h0000_0000;
    if (addr_q == OFF_CTRL1) begin
      rmux = {16'h0000, ctrl1_rd};
    end else if (addr_q == OFF_CTRL2) begin
      rmux = {8'h00, div_q, 3'h0, acqt_q, 6'h00, cc_eff};
    end else if (addr_q == OFF_STAT) begin
      rmux = {24'h00_0000, 2'h0, idx_q, wp_q};
    end else if (addr_q[7:6] == BUF_PAGE) begin
      rmux = {16'h0000, buf_q[addr_q[5:2]]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      addr_q    <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      wr_q      <= acc && hwrite;
      rd_q      <= acc && !hwrite;
      addr_q    <= acc ? haddr : addr_q;
      hreadyout <= !(acc && !hwrite);
      hrdata    <= rd_q ? rmux : hrdata;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_q   <= CTRL1_RESET[B_ON];
      halt_q <= CTRL1_RESET[B_HALT];
      wide_q <= CTRL1_RESET[B_WIDE];
      lay_q  <= CTRL1_RESET[B_LAY+:2];
      trig_q <= CTRL1_RESET[B_TRIG+:3];
      par_q  <= CTRL1_RESET[B_PAR];
      auto_q <= CTRL1_RESET[B_AUTO];
    end else if (wr_c1) begin
      on_q   <= hwdata[B_ON];
      halt_q <= hwdata[B_HALT];
      wide_q <= hwdata[B_WIDE];
      lay_q  <= hwdata[B_LAY+:2];
      trig_q <= hwdata[B_TRIG+:3];
      par_q  <= hwdata[B_PAR];
      auto_q <= hwdata[B_AUTO];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cc_q   <= 2'h0;
      acqt_q <= ACQT_RESET;
      div_q  <= DIV_RESET;
    end else if (wr_c2) begin
      cc_q   <= hwdata[B_CC+:2];
      acqt_q <= hwdata[B_ACQT+:5];
      div_q  <= hwdata[B_DIV+:8];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else if (fin) begin
      done_q <= 1'b1;
    end else if (start_d && sampling) begin
      done_q <= 1'b0;
    end else if (wr_c1 && !hwdata[B_DONE]) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q        <= S_IDLE;
      idx_q       <= 2'h0;
      core_req    <= '0;
      sample_hold <= 4'h0;
      tad_q       <= 8'h00;
      acq_q       <= 5'h00;
    end else begin
      st_q           <= st_d;
      idx_q          <= idx_d;
      core_req.start <= start_d;
      core_req.chan  <= idx_d;
      core_req.wide  <= wide_q;
      sample_hold    <= (st_d != S_SAMPLE) ? 4'h0 :
                        par_eff ? chan_mask(wide_q, cc_q) :
                        (4'h1 << idx_d);
      tad_q          <= (!sampling || tad_tick) ? 8'h00 : tad_q + 8'h01;
      acq_q          <= !sampling ? 5'h00 :
                        (tad_tick && !auto_fire) ? acq_q + 5'h01 : acq_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= 4'h0;
    end else if (store) begin
      wp_q <= wp_q + 4'h1;
    end
  end

  always_ff @(posedge hclk) begin
    if (store) begin
      buf_q[wp_q] <= fmt_word;
    end
  end

  a_off_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    !run |=> (st_q == S_IDLE) && !core_req.start)
    else $error("sequencer active while off or halted");

  a_wide_single: assert property (@(posedge hclk) disable iff (!hresetn)
    wide_q && $stable(wide_q) |=> $onehot0(sample_hold) && !sample_hold[3])
    else $error("several channels sampled in 12-bit mode");

  a_par_all: assert property (@(posedge hclk) disable iff (!hresetn)
    sampling && par_q && !wide_q && cc_q[1] && $stable(cc_q) && $stable(par_q)
      |-> sample_hold == 4'hF)
    else $error("parallel hold did not sample all four channels");

  a_seq_single: assert property (@(posedge hclk) disable iff (!hresetn)
    !par_q && $stable(par_q) |-> $onehot0(sample_hold))
    else $error("sequential mode sampled two channels");

  a_trig_start: assert property (@(posedge hclk) disable iff (!hresetn)
    sampling && trig_evt && run |=> core_req.start && !sampling ##1 !core_req.start)
    else $error("trigger did not end sampling with one start pulse");

  a_sw_only: assert property (@(posedge hclk) disable iff (!hresetn)
    sampling && trig_q == T_SW && !wr_c1 |=> st_q != S_CONVERT)
    else $error("conversion started without software trigger");

  a_done_set: assert property (@(posedge hclk) disable iff (!hresetn)
    fin |=> done_q && (wp_q == $past(wp_q) + 4'h1))
    else $error("done or buffer pointer wrong after last result");

  a_done_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    sampling && start_d |=> !done_q)
    else $error("done not cleared at conversion start");

  a_auto_again: assert property (@(posedge hclk) disable iff (!hresetn)
    fin && auto_q && run |=> sampling)
    else $error("auto start did not resume sampling");

  a_acq_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    sampling && trig_q == T_AUTO && (acq_q + 5'h01 < acqt_q) |=> st_q != S_CONVERT)
    else $error("counter trigger fired early");

  a_ctrl_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_q && addr_q == OFF_CTRL1 |=> hrdata[14] == 1'b0 && hrdata[12:11] == 2'h0
      && hrdata[4] == 1'b0 && (!wide_q || !hrdata[3]))
    else $error("unimplemented control bits read nonzero");

  c_parallel: cover property (@(posedge hclk) disable iff (!hresetn)
    fin && par_eff && cc_q[1]);
  c_auto_trig: cover property (@(posedge hclk) disable iff (!hresetn)
    sampling && trig_q == T_AUTO && auto_fire && acqt_q != 5'h00);
  c_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
    store && wp_q == 4'hF);
  c_sequential: cover property (@(posedge hclk) disable iff (!hresetn)
    store && !last && !par_eff);
endmodule
`default_nettype wire

// >>> adcs_core_model.sv
/*
  Converter core model: answers every start with one done pulse and a raw result.
  Assumes start pulses on hclk; slow selects a long conversion time.
*/
`timescale 1ns/1ns
`default_nettype none
module adcs_core_model (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        slow,
  input  wire adcs_pkg::adcs_core_req_type req,
  output var  adcs_pkg::adcs_core_rsp_type rsp
);
  import adcs_pkg::*;
  int          cnt;
  logic [11:0] res;
  logic        fin;
  assign fin = (cnt == 1) && !req.start;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      res <= '0;
      rsp <= '0;
    end else begin
      rsp.done <= fin;
      // data not held outside the done cycle
      rsp.data <= fin ? res : ~rsp.data;
      if (req.start) begin
        cnt <= slow ? 9 : 1;
        res <= (req.wide ? 12'hA5C : 12'h25C) ^ {10'h0, req.chan} ^ (slow ? (req.wide ? 12'hFFF : 12'h3FF) : 12'h0);
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench.sv
/*
  Self-checking bench for the converter control sequencer.
  Assumes the package, design files and core model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) check(32'(a), 32'(e))
module testbench;
  import adcs_pkg::*;
  logic              hclk;
  logic              hresetn;
  logic              hsel;
  logic [7:0]        haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [2:0]        hsize;
  logic [31:0]       hwdata;
  logic              hreadyout;
  logic [31:0]       hrdata;
  logic              hresp;
  logic              chip_idle;
  logic              ext_pin_zero;
  logic              slow;
  adcs_trig_type     trig;
  adcs_core_req_type core_req;
  adcs_core_rsp_type core_rsp;
  logic [3:0]        sample_hold;
  int                fail_count = 0;
  int                num_checks = 0;
  int                starts = 0;
  int                ptr = 0;

  adcs_top #(.BUF_DEPTH(16)) i_adcs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .chip_idle(chip_idle),
    .ext_pin_zero(ext_pin_zero), .trig_in(trig), .core_rsp(core_rsp), .core_req(core_req),
    .sample_hold(sample_hold));
  adcs_core_model i_adcs_core_model (.hclk(hclk), .hresetn(hresetn), .slow(slow), .req(core_req),
    .rsp(core_rsp));

  always @(posedge hclk) begin
    if (core_req.start === 1'b1) starts <= starts + 1;
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] a, input logic [31:0] e);
    num_checks++;
    if (a !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, a, e);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q & m, e);
  endtask

  function automatic logic [31:0] c1(logic on, logic hi, logic w, logic [1:0] l, logic [2:0] t, logic p,
                                     logic au, logic sp);
    return {16'h0, on, 1'b0, hi, 2'b0, w, l, t, 1'b0, p, au, sp, 1'b0};
  endfunction

  function automatic logic [31:0] c2(logic [1:0] cc, logic [4:0] at);
    return {16'h0, 3'h0, at, 6'h0, cc};
  endfunction

  function automatic logic [11:0] raw(logic w);
    return (w ? 12'hA5C : 12'h25C) ^ (slow ? (w ? 12'hFFF : 12'h3FF) : 12'h0);
  endfunction

  function automatic logic [15:0] fmt(logic w, logic [1:0] l, logic [11:0] r);
    case ({w, l})
      3'h0: return {6'h0, r[9:0]};
      3'h1: return {{7{~r[9]}}, r[8:0]};
      3'h2: return {r[9:0], 6'h0};
      3'h3: return {~r[9], r[8:0], 6'h0};
      3'h4: return {4'h0, r};
      3'h5: return {{5{~r[11]}}, r[10:0]};
      3'h6: return {r, 4'h0};
      default: return {~r[11], r[10:0], 4'h0};
    endcase
  endfunction

  function automatic logic [3:0] sel(logic [2:0] c);
    case (c)
      T_EXTERNAL_INTERRUPT_PIN_ZERO: return 4'h1;
      T_TMR3: return 4'h2;
      T_PWM1: return 4'h4;
      T_PWM2: return 4'h8;
      default: return 4'h0;
    endcase
  endfunction

  // pulse the chosen trigger sources; pin held long enough for its synchroniser
  task automatic fire(input logic [3:0] m);
    ext_pin_zero <= m[0];
    trig <= {m[1], m[2], m[3]};
    @(posedge hclk);
    trig <= '0;
    repeat (6) @(posedge hclk);
    ext_pin_zero <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask

  task automatic waitdone;
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, OFF_CTRL1, 32'h0, q);
      n++;
    end while (q[B_DONE] !== 1'b1 && n < 40);
    `CHK(q[B_DONE], 1'b1);
  endtask

  task automatic t_regs;
    rdc(OFF_CTRL1, 32'hFFFF_FFFF, CTRL1_RESET);
    wr(OFF_CTRL1, 32'h5810);
    rdc(OFF_CTRL1, 32'hFFFF_FFFF, 32'h0);
    rdc(8'h3C, 32'hFFFF_FFFF, 32'h0);
    `CHK(hresp, 1'b0);
  endtask

  task automatic t_off;
    int s0;
    s0 = starts;
    wr(OFF_CTRL2, c2(2'h0, 5'h1));
    wr(OFF_CTRL1, c1(0, 0, 0, 0, T_AUTO, 0, 1, 1));
    fire(4'hF);
    repeat (20) @(posedge hclk);
    `CHK(starts, s0);
    `CHK(sample_hold, 4'h0);
  endtask

  task automatic t_format;
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      for (int k = 0; k < 8; k++) begin
        wr(OFF_CTRL1, 32'h0);
        wr(OFF_CTRL1, c1(0, 0, k[2], k[1:0], T_SW, 0, 0, 0));
        wr(OFF_CTRL2, c2(2'h0, 5'h0));
        wr(OFF_CTRL1, c1(1, 0, k[2], k[1:0], T_SW, 0, 0, 0));
        wr(OFF_CTRL1, c1(1, 0, k[2], k[1:0], T_SW, 0, 0, 1));
        wr(OFF_CTRL1, c1(1, 0, k[2], k[1:0], T_SW, 0, 0, 0));
        waitdone;
        `CHK(core_req.wide, k[2]);
        rdc(8'h40 + 8'(4 * ptr), 32'hFFFF, fmt(k[2], k[1:0], raw(k[2])));
        ptr = (ptr + 1) % 16;
        rdc(OFF_STAT, 32'hF, ptr);
      end
    end
  endtask

  task automatic t_trig;
    int s0;
    int n;
    logic ok;
    slow <= 1'b0;
    for (int k = 1; k < 8; k++) begin
      if (k == 4 || k == 6) continue;
      ok = 1'b1;
      wr(OFF_CTRL1, 32'h0);
      wr(OFF_CTRL2, c2(2'h0, 5'h3));
      wr(OFF_CTRL1, c1(1, 0, 0, 0, k[2:0], 0, 0, 0));
      wr(OFF_CTRL1, c1(1, 0, 0, 0, k[2:0], 0, 0, 1));
      s0 = starts;
      if (k != 7) begin
        fire(~sel(k[2:0]));
        `CHK(starts, s0);
        fire(sel(k[2:0]));
      end
      n = 0;
      while (starts == s0 && n < 30) begin
        @(posedge hclk);
        n++;
      end
      `CHK(starts - s0, ok);
      if (k == 7) `CHK(n, 5);
      if (ok) waitdone;
      rdc(OFF_CTRL1, 32'h2, {30'h0, ~ok, 1'b0});
    end
  endtask

  task automatic t_par;
    logic [11:0] tc [4] = '{12'h6F4, 12'h532, 12'h211, 12'hE11};
    logic [11:0] c;
    logic [31:0] q;
    int s0;
    for (int i = 0; i < 4; i++) begin
      c = tc[i];
      wr(OFF_CTRL1, 32'h0);
      wr(OFF_CTRL2, c2(c[9:8], 5'h0));
      wr(OFF_CTRL1, c1(1, 0, c[11], 0, T_SW, c[10], 0, 0));
      wr(OFF_CTRL1, c1(1, 0, c[11], 0, T_SW, c[10], 0, 1));
      s0 = starts;
      rdc(OFF_CTRL1, 32'h8, {28'h0, c[10] & ~c[11], 3'h0});
      rdc(OFF_CTRL2, 32'h3, c[11] ? 2'h0 : c[9:8]);
      `CHK(sample_hold, c[7:4]);
      wr(OFF_CTRL1, c1(1, 0, c[11], 0, T_SW, c[10], 0, 0));
      repeat (60) @(posedge hclk);
      `CHK(starts - s0, c[3:0]);
      bus(1'b0, OFF_STAT, 32'h0, q);
      rdc(8'h40 + 8'({q[3:0] - 4'h1, 2'h0}), 32'hFFFF,
          fmt(c[11], 2'h0, raw(c[11]) ^ 12'(c[3:0] - 4'h1)));
    end
  endtask

  task automatic t_auto;
    int s0;
    wr(OFF_CTRL1, 32'h0);
    wr(OFF_CTRL2, c2(2'h0, 5'h1));
    chip_idle <= 1'b1;
    wr(OFF_CTRL1, c1(1, 1, 0, 0, T_AUTO, 0, 1, 0));
    s0 = starts;
    repeat (40) @(posedge hclk);
    `CHK(starts, s0);
    chip_idle <= 1'b0;
    repeat (60) @(posedge hclk);
    `CHK(starts - s0 >= 3, 1'b1);
    chip_idle <= 1'b1;
    wr(OFF_CTRL1, c1(1, 0, 0, 0, T_AUTO, 0, 1, 0));
    s0 = starts;
    repeat (60) @(posedge hclk);
    `CHK(starts - s0 >= 3, 1'b1);
    wr(OFF_CTRL1, 32'h0);
    repeat (10) @(posedge hclk);
    s0 = starts;
    repeat (40) @(posedge hclk);
    `CHK(starts, s0);
    chip_idle <= 1'b0;
  endtask

  task automatic t_done;
    slow <= 1'b1;
    wr(OFF_CTRL2, c2(2'h0, 5'h0));
    wr(OFF_CTRL1, c1(1, 0, 0, 0, T_SW, 0, 0, 0));
    wr(OFF_CTRL1, c1(1, 0, 0, 0, T_SW, 0, 0, 1));
    wr(OFF_CTRL1, c1(1, 0, 0, 0, T_SW, 0, 0, 0));
    // done cleared while the slow conversion is still running
    wr(OFF_CTRL1, c1(1, 0, 0, 0, T_SW, 0, 0, 0));
    waitdone;
    wr(OFF_CTRL1, c1(1, 0, 0, 0, T_SW, 0, 0, 0));
    rdc(OFF_CTRL1, 32'h1, 32'h0);
  endtask

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  initial begin
    repeat (30000) @(posedge hclk);
    fail_count++;
    report_and_stop;
  end

  initial begin
    hresetn = 1'b0;
    hsize = 3'h2;
    {hsel, hwrite, chip_idle, ext_pin_zero, slow, trig, haddr, htrans, hwdata} = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_off;
    t_format;
    t_trig;
    t_par;
    t_auto;
    t_done;
    report_and_stop;
  end
endmodule
`undef CHK
`default_nettype wire
